//--- pmn_limits_status.sv
`timescale 1ns/1ps

module pmn_limits_status
   import pmn_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire pmn_req_type req_in,
   input wire logic comm_err_in,
   input wire pmn_adc_type adc_in,
   input wire logic second_warn_direction_select_in,
   input wire logic other_status_in,
   input wire logic gate_drive_off_pin_in,
   input wire logic overcurrent_trip_pin_in,
   input wire logic undervoltage_comparator_pin_in,
   output logic [15:0] rdata_out,
   output logic rack_out,
   output logic [7:0] status_out,
   output logic [3:0] warn_out
);

   //////////////////////////////////////////////////////////////////////////////
   // Declarations.

   // Registered state and its next value.
   pmn_regs_type regs_q;
   pmn_regs_type regs_d;
   // Synchronised pin levels: gate off, overcurrent trip, undervoltage fault.
   logic [2:0] pin_level;
   // Named views of the synchronised pins.
   logic gate_off_s;
   logic oc_trip_s;
   logic uv_fault_s;
   // Send-byte clear seen this cycle.
   logic clear_cmd;
   // Threshold comparison results for the current ADC result.
   logic [3:0] warn_hit;
   // Low twelve bits of the write data, used by the threshold writes and the checks.
   logic [11:0] wdata12;

   //////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   // The hot-swap pins come from analog logic with no relation to clk_in.
   pmn_pin_sync #(
      .W(3)
   ) u_pin_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pin_in({undervoltage_comparator_pin_in, overcurrent_trip_pin_in, gate_drive_off_pin_in}),
      .level_out(pin_level)
   );

   assign gate_off_s = pin_level[0];
   assign oc_trip_s = pin_level[1];
   assign uv_fault_s = pin_level[2];
   assign clear_cmd = req_in.send && (req_in.code == PMN_CODE_CLEAR);
   assign wdata12 = req_in.wdata[11:0];

   //////////////////////////////////////////////////////////////////////////////
   // Threshold comparators.

   // Each result is compared only against the thresholds of its own channel.
   // The second current limit is an overcurrent limit when the direction
   // select is high and an undercurrent limit when it is low.
   always_comb begin
      warn_hit = '0;
      if (adc_in.valid && adc_in.chan == PMN_CHAN_CURRENT) begin
         warn_hit[PMN_WARN_CUR_HIGH] = adc_in.code > regs_q.cur_high;
         if (second_warn_direction_select_in) begin
            warn_hit[PMN_WARN_CUR_SECOND] = adc_in.code > regs_q.cur_second;
         end else begin
            warn_hit[PMN_WARN_CUR_SECOND] = adc_in.code < regs_q.cur_second;
         end
      end
      if (adc_in.valid && adc_in.chan == PMN_CHAN_VIN) begin
         warn_hit[PMN_WARN_VIN_OV] = adc_in.code > regs_q.vin_ov;
         warn_hit[PMN_WARN_VIN_UV] = adc_in.code < regs_q.vin_uv;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Next state.

   // Writes land at the next edge. Latched bits are cleared by the clear
   // command, but a cause present in the same cycle sets them again, so no
   // event is lost to a clear that races it.
   always_comb begin
      regs_d = regs_q;
      regs_d.rack = 1'b0;

      // Threshold writes; the reserved nibble is never stored.
      if (req_in.wr) begin
         case (req_in.code)
            PMN_CODE_CUR_HIGH: begin
               regs_d.cur_high = wdata12;
            end
            PMN_CODE_CUR_SECOND: begin
               regs_d.cur_second = wdata12;
            end
            PMN_CODE_VIN_OV: begin
               regs_d.vin_ov = wdata12;
            end
            PMN_CODE_VIN_UV: begin
               regs_d.vin_uv = wdata12;
            end
            default: begin
               // Writes to the status byte or unknown codes are dropped.
               regs_d.rack = 1'b0;
            end
         endcase
      end

      // Latched bits: clear first, then set, so the set wins.
      if (clear_cmd) begin
         regs_d.oc_fault = 1'b0;
         regs_d.uv_fault = 1'b0;
         regs_d.comm_err = 1'b0;
         regs_d.warn = '0;
      end
      if (oc_trip_s) begin
         regs_d.oc_fault = 1'b1;
      end
      if (uv_fault_s) begin
         regs_d.uv_fault = 1'b1;
      end
      if (comm_err_in) begin
         regs_d.comm_err = 1'b1;
      end
      regs_d.warn = regs_d.warn | warn_hit;

      // Status byte built from the next flags so it moves with them.
      regs_d.status = PMN_RST_STATUS;
      regs_d.status[PMN_ST_GATE_OFF] = gate_off_s;
      regs_d.status[PMN_ST_OC_FAULT] = regs_d.oc_fault;
      regs_d.status[PMN_ST_UV_FAULT] = regs_d.uv_fault;
      regs_d.status[PMN_ST_COMM_ERR] = regs_d.comm_err;
      // Our own warnings are reported by the other status pending bit.
      regs_d.status[PMN_ST_OTHER] = other_status_in | (|regs_d.warn);

      // Reads answer one cycle later and the data hold until the next read.
      if (req_in.rd) begin
         regs_d.rack = 1'b1;
         case (req_in.code)
            PMN_CODE_CUR_HIGH: begin
               regs_d.rdata = {PMN_RSVD_NIBBLE, regs_q.cur_high};
            end
            PMN_CODE_CUR_SECOND: begin
               regs_d.rdata = {PMN_RSVD_NIBBLE, regs_q.cur_second};
            end
            PMN_CODE_VIN_OV: begin
               regs_d.rdata = {PMN_RSVD_NIBBLE, regs_q.vin_ov};
            end
            PMN_CODE_VIN_UV: begin
               regs_d.rdata = {PMN_RSVD_NIBBLE, regs_q.vin_uv};
            end
            PMN_CODE_STATUS: begin
               regs_d.rdata = {PMN_RSVD_BYTE, regs_q.status};
            end
            default: begin
               // Unknown codes read as zero; the engine flags them itself.
               regs_d.rdata = PMN_RD_UNMAPPED;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // State register.

   // Reset loads the documented defaults; limits that start wide open keep
   // warnings quiet until software programs real values, except the second
   // current limit, which warns on any nonzero current with direction select high.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         regs_q <= '0;
         regs_q.cur_high <= PMN_RST_ALL_ONES;
         regs_q.cur_second <= PMN_RST_ZERO;
         regs_q.vin_ov <= PMN_RST_ALL_ONES;
         regs_q.vin_uv <= PMN_RST_ZERO;
         regs_q.status <= PMN_RST_STATUS;
      end else begin
         regs_q <= regs_d;
      end
   end

   // Every output is a flip-flop.
   assign rdata_out = regs_q.rdata;
   assign rack_out = regs_q.rack;
   assign status_out = regs_q.status;
   assign warn_out = regs_q.warn;

   //////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking pmn_cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   // Reserved threshold bits and status bits never read as one.
   rsvd_read_a: assert property (
      rack_out && !$past(req_in.code == PMN_CODE_STATUS) |-> rdata_out[15:12] == PMN_RSVD_NIBBLE)
      else $error("Reserved threshold bits read as one.");

   status_rsvd_a: assert property (
      !status_out[7] && !status_out[5] && !status_out[2])
      else $error("Reserved status bit set.");

   // Written threshold comes back masked on the following read.
   thr_echo_a: assert property (
      req_in.wr && req_in.code == PMN_CODE_CUR_HIGH ##1 req_in.rd && req_in.code == PMN_CODE_CUR_HIGH
      |=> rack_out && rdata_out == {PMN_RSVD_NIBBLE, $past(wdata12, 2)})
      else $error("Current high threshold did not read back.");

   // Gate drive status follows the synchronised pin one cycle later.
   gate_live_a: assert property (
      gate_off_s |=> status_out[PMN_ST_GATE_OFF])
      else $error("Gate drive off not reported.");

   oc_latch_a: assert property (
      oc_trip_s |=> status_out[PMN_ST_OC_FAULT] && warn_out == $past(regs_d.warn))
      else $error("Overcurrent trip not latched.");

   uv_latch_a: assert property (
      uv_fault_s ##1 (!uv_fault_s && !clear_cmd) [*2] |=> status_out[PMN_ST_UV_FAULT])
      else $error("Undervoltage fault lost before clear.");

   comm_set_a: assert property (
      comm_err_in |=> status_out[PMN_ST_COMM_ERR])
      else $error("Communication error not latched even against a clear.");

   other_live_a: assert property (
      (other_status_in || |warn_hit) |=> status_out[PMN_ST_OTHER])
      else $error("Other status pending not shown.");

   latch_hold_a: assert property (
      status_out[PMN_ST_OC_FAULT] && !clear_cmd |=> status_out[PMN_ST_OC_FAULT])
      else $error("Latched overcurrent dropped without a clear.");

   clear_all_a: assert property (
      clear_cmd && !comm_err_in && !oc_trip_s && !uv_fault_s && !adc_in.valid
      |=> !status_out[PMN_ST_OC_FAULT] && !status_out[PMN_ST_UV_FAULT] &&
          !status_out[PMN_ST_COMM_ERR] && warn_out == '0)
      else $error("Clear command left a latched bit set.");

   vin_ov_a: assert property (
      adc_in.valid && adc_in.chan == PMN_CHAN_VIN && adc_in.code > regs_q.vin_ov
      |=> warn_out[PMN_WARN_VIN_OV] && status_out[PMN_ST_OTHER])
      else $error("Input overvoltage warning not set.");

   warn2_dir_a: assert property (
      adc_in.valid && adc_in.chan == PMN_CHAN_CURRENT && !second_warn_direction_select_in &&
      adc_in.code < regs_q.cur_second |=> warn_out[PMN_WARN_CUR_SECOND])
      else $error("Undercurrent warning not set.");

   // A status read returns the byte that stood when the read was taken.
   status_read_a: assert property (
      req_in.rd && req_in.code == PMN_CODE_STATUS
      |=> rack_out && rdata_out == {PMN_RSVD_BYTE, $past(status_out)})
      else $error("Status byte read returned a wrong value.");

   // Every read is answered exactly one cycle after it is taken.
   rack_pulse_a: assert property (
      req_in.rd |=> rack_out)
      else $error("Read was not answered.");

   // The answer never rises without a read, so the engine cannot see a ghost reply.
   rack_quiet_a: assert property (
      !req_in.rd |=> !rack_out)
      else $error("Read answer raised without a read.");

   // A current result above the high limit raises its warning.
   cur_high_warn_a: assert property (
      adc_in.valid && adc_in.chan == PMN_CHAN_CURRENT && adc_in.code > regs_q.cur_high
      |=> warn_out[PMN_WARN_CUR_HIGH])
      else $error("Current high warning not set.");

   // With the direction select high the second limit acts as an overcurrent limit.
   warn2_over_a: assert property (
      adc_in.valid && adc_in.chan == PMN_CHAN_CURRENT && second_warn_direction_select_in &&
      adc_in.code > regs_q.cur_second |=> warn_out[PMN_WARN_CUR_SECOND])
      else $error("Second current overcurrent warning not set.");

   // An input result below the undervoltage limit raises its warning.
   vin_uv_warn_a: assert property (
      adc_in.valid && adc_in.chan == PMN_CHAN_VIN && adc_in.code < regs_q.vin_uv
      |=> warn_out[PMN_WARN_VIN_UV])
      else $error("Input undervoltage warning not set.");

   // A result equal to the limit is not past it, so the warning must not move.
   equal_quiet_a: assert property (
      adc_in.valid && adc_in.chan == PMN_CHAN_VIN && adc_in.code == regs_q.vin_ov && !clear_cmd
      |=> warn_out[PMN_WARN_VIN_OV] == $past(warn_out[PMN_WARN_VIN_OV]))
      else $error("Input overvoltage warning set by an equal result.");

endmodule : pmn_limits_status

//--- pmn_pkg.sv
package pmn_pkg;

   //////////////////////////////////////////////////////////////////////////////
   // Command codes seen on the command port.

   // Current high-warning threshold word.
   localparam logic [7:0] PMN_CODE_CUR_HIGH = 8'h4A;
   // Input overvoltage warning threshold word.
   localparam logic [7:0] PMN_CODE_VIN_OV = 8'h57;
   // Input undervoltage warning threshold word.
   localparam logic [7:0] PMN_CODE_VIN_UV = 8'h58;
   // Summary status byte, read only.
   localparam logic [7:0] PMN_CODE_STATUS = 8'h78;
   // Second current warning threshold word.
   localparam logic [7:0] PMN_CODE_CUR_SECOND = 8'hD7;
   // Send-byte command that clears every latched status bit.
   localparam logic [7:0] PMN_CODE_CLEAR = 8'h03;

   //////////////////////////////////////////////////////////////////////////////
   // Reset values and widths.

   // Width of every threshold field and of an ADC code.
   localparam int PMN_ADC_W = 12;
   // Reset value of the current high and input overvoltage thresholds.
   localparam logic [11:0] PMN_RST_ALL_ONES = 12'hFFF;
   // Reset value of the second current and input undervoltage thresholds.
   localparam logic [11:0] PMN_RST_ZERO = 12'h000;
   // Reserved upper nibble of a threshold word.
   localparam logic [3:0] PMN_RSVD_NIBBLE = 4'h0;
   // Upper byte returned with the status byte.
   localparam logic [7:0] PMN_RSVD_BYTE = 8'h00;
   // Answer to a read of a code this block does not hold.
   localparam logic [15:0] PMN_RD_UNMAPPED = 16'h0000;
   // Reset value of the status byte.
   localparam logic [7:0] PMN_RST_STATUS = 8'h00;

   //////////////////////////////////////////////////////////////////////////////
   // Summary status byte bit positions.

   // Gate drive off, live.
   localparam int PMN_ST_GATE_OFF = 6;
   // Overcurrent trip fault, latched.
   localparam int PMN_ST_OC_FAULT = 4;
   // Input undervoltage fault, latched.
   localparam int PMN_ST_UV_FAULT = 3;
   // Bus communication error, latched.
   localparam int PMN_ST_COMM_ERR = 1;
   // Other status pending: the live input ORed with the latched warnings.
   localparam int PMN_ST_OTHER = 0;

   // Warning flag positions in the latched warning vector.
   localparam int PMN_WARN_CUR_HIGH = 0;
   localparam int PMN_WARN_CUR_SECOND = 1;
   localparam int PMN_WARN_VIN_OV = 2;
   localparam int PMN_WARN_VIN_UV = 3;
   // Number of latched warning flags.
   localparam int PMN_WARN_N = 4;

   //////////////////////////////////////////////////////////////////////////////
   // Types.

   // Which measurement an ADC result belongs to.
   typedef enum logic [1:0] {
      PMN_CHAN_CURRENT = 2'h1,
      PMN_CHAN_VIN = 2'h2
   } pmn_chan_type;

   // One command from the bus transaction engine, valid for one cycle.
   typedef struct packed {
      logic wr;
      logic rd;
      logic send;
      logic [7:0] code;
      logic [15:0] wdata;
   } pmn_req_type;

   // One finished ADC conversion, valid for one cycle.
   typedef struct packed {
      logic valid;
      pmn_chan_type chan;
      logic [11:0] code;
   } pmn_adc_type;

   // Whole state of the register bank.
   typedef struct packed {
      logic [11:0] cur_high;
      logic [11:0] cur_second;
      logic [11:0] vin_ov;
      logic [11:0] vin_uv;
      logic oc_fault;
      logic uv_fault;
      logic comm_err;
      logic [3:0] warn;
      logic [15:0] rdata;
      logic rack;
      logic [7:0] status;
   } pmn_regs_type;

endpackage : pmn_pkg

//--- pmn_pin_sync.sv
`timescale 1ns/1ps

module pmn_pin_sync #(
   parameter int W = 3
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);

   // Three flip-flops per pin and the accepted level.
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } pmn_sync_type;

   pmn_sync_type sync_q;
   pmn_sync_type sync_d;

   //////////////////////////////////////////////////////////////////////////////

   // A change is taken only once the second and third stages agree, so a pin
   // caught mid-transition never yields a one-cycle glitch on the level.
   // The first stage feeds the second stage only.
   always_comb begin
      sync_d = sync_q;
      sync_d.s1 = pin_in;
      sync_d.s2 = sync_q.s1;
      sync_d.s3 = sync_q.s2;
      sync_d.level = (~(sync_q.s2 ^ sync_q.s3) & sync_q.s3) |
                     ((sync_q.s2 ^ sync_q.s3) & sync_q.level);
   end

   // All stages clear under reset.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_q <= '0;
      end else begin
         sync_q <= sync_d;
      end
   end

   assign level_out = sync_q.level;

endmodule : pmn_pin_sync

//--- pmn_host_model.sv
`timescale 1ns/1ps

module pmn_host_model
   import pmn_pkg::*;
(
   input wire logic clk_in,
   output pmn_req_type req_out
);

   //////////////////////////////////////////////////////////////////////////////
   // Command port driver, standing where the bus transaction engine sits.

   // The port starts quiet so nothing is taken during or just after reset.
   initial begin
      req_out = '0;
   end

   // Places one request just after an edge; it stays until the next put or idle.
   task automatic put(input logic w, input logic r, input logic s, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_in);
      #2;
      req_out = '{wr: w, rd: r, send: s, code: c, wdata: d};
   endtask : put

   // Drops the strobes; code and data flip so a stale value is never mistaken for a live one.
   task automatic idle();
      @(posedge clk_in);
      #2;
      req_out = '{wr: 1'b0, rd: 1'b0, send: 1'b0, code: ~req_out.code, wdata: ~req_out.wdata};
   endtask : idle

   // Releases latched faults; the device keeps them until this arrives.
   task automatic clear_all();
      put(1'b0, 1'b0, 1'b1, PMN_CODE_CLEAR, 16'h0000);
      idle();
   endtask : clear_all

endmodule : pmn_host_model

//--- power_monitor_limits_status_tb_top.sv
`timescale 1ns/1ps

module power_monitor_limits_status_tb_top
   import pmn_pkg::*;
;

   //////////////////////////////////////////////////////////////////////////////
   // Signals around the block.

   logic clk_in;
   logic rst_in;
   pmn_req_type req;
   logic comm_err;
   pmn_adc_type adc;
   logic dir_sel;
   logic other;
   logic [2:0] pins; // Gate off, overcurrent trip, undervoltage comparator.
   logic [15:0] rdata;
   logic rack;
   logic [7:0] status;
   logic [3:0] warn;
   // Expected state of the status byte and warnings, kept by the stimulus.
   logic e_gate, e_oc, e_uv, e_ce;
   logic [3:0] e_warn;
   logic [15:0] exp_q[$];
   logic [15:0] e_rd;
   logic [18:0] tbl [7];
   logic [7:0] codes [4];
   logic [15:0] d;
   int fail_count;
   int total_checks;
   int cycles;

   pmn_host_model host (.clk_in(clk_in), .req_out(req));

   pmn_limits_status uut (
      .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .comm_err_in(comm_err), .adc_in(adc),
      .second_warn_direction_select_in(dir_sel), .other_status_in(other),
      .gate_drive_off_pin_in(pins[0]), .overcurrent_trip_pin_in(pins[1]),
      .undervoltage_comparator_pin_in(pins[2]), .rdata_out(rdata), .rack_out(rack),
      .status_out(status), .warn_out(warn)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Clock, timeout and verdict.

   // Half of the 50 ns period.
   always #25 clk_in = ~clk_in;

   // Cuts a hang short; the whole sequence needs well under a thousand cycles.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (fail_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   //////////////////////////////////////////////////////////////////////////////
   // Read answer monitor: every answer takes the oldest note off the queue.

   always @(posedge clk_in) begin
      #1;
      if (rack === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unrequested answer", 16'h0000, 16'hFFFF);
         end else begin
            e_rd = exp_q.pop_front();
            chk("rdata_out", e_rd, rdata);
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Bus and stimulus tasks.

   // Expected status word: reserved bits 7, 5, 2 and the upper byte stay zero.
   function automatic logic [15:0] st();
      return {8'h00, 1'b0, e_gate, 1'b0, e_oc, e_uv, 1'b0, e_ce, other | (|e_warn)};
   endfunction : st

   // A write is left standing so a following read lands in the very next cycle.
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      host.put(1'b1, 1'b0, 1'b0, c, v);
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      host.put(1'b0, 1'b1, 1'b0, c, 16'($urandom));
      exp_q.push_back(e);
      // The byte on the status port must already match what the read will return.
      if (c == PMN_CODE_STATUS) begin
         chk("status_out", e, {8'h00, status});
      end
      host.idle();
   endtask : rd

   // Pins move at the usual stimulus offset; the synchroniser absorbs any phase.
   task automatic set_pin(input int i, input logic v);
      pins[i] = v;
      repeat (6) @(posedge clk_in);
      #2;
   endtask : set_pin

   //////////////////////////////////////////////////////////////////////////////
   // Main sequence.

   initial begin
      clk_in = 1'b0;
      rst_in = 1'b1;
      adc = '0;
      comm_err = 1'b0;
      dir_sel = 1'b1;
      other = 1'b0;
      pins = 3'h0;
      {e_gate, e_oc, e_uv, e_ce, e_warn} = '0;
      void'($urandom(32'hA5A0));
      codes = '{PMN_CODE_CUR_HIGH, PMN_CODE_CUR_SECOND, PMN_CODE_VIN_OV, PMN_CODE_VIN_UV};
      // Each entry: direction, channel, code, warnings newly expected.
      tbl = '{{1'b1, 2'h1, 12'h200, 4'h0}, {1'b1, 2'h1, 12'h401, 4'h3}, {1'b0, 2'h1, 12'h200, 4'h0},
              {1'b0, 2'h1, 12'h1FF, 4'h2}, {1'b0, 2'h2, 12'h800, 4'h0}, {1'b0, 2'h2, 12'h100, 4'h0},
              {1'b0, 2'h2, 12'h801, 4'h4}};
      repeat (3) @(posedge clk_in);
      #2;
      rst_in = 1'b0;
      // Reset values, then an unmapped code.
      rd(PMN_CODE_CUR_HIGH, 16'h0FFF);
      rd(PMN_CODE_CUR_SECOND, 16'h0000);
      rd(PMN_CODE_VIN_OV, 16'h0FFF);
      rd(PMN_CODE_VIN_UV, 16'h0000);
      rd(PMN_CODE_STATUS, 16'h0000);
      rd(8'h79, 16'h0000);
      // Random words, each read back in the cycle after the write.
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom) | 16'hF000;
         wr(codes[i], d);
         rd(codes[i], {4'h0, d[11:0]});
      end
      // The status byte refuses writes.
      wr(PMN_CODE_STATUS, 16'hFFFF);
      rd(PMN_CODE_STATUS, st());
      // Thresholds for the comparisons, written back to back.
      wr(PMN_CODE_CUR_HIGH, 16'h0400);
      wr(PMN_CODE_CUR_SECOND, 16'h0200);
      wr(PMN_CODE_VIN_OV, 16'h0800);
      wr(PMN_CODE_VIN_UV, 16'h0100);
      rd(PMN_CODE_VIN_UV, 16'h0100);
      // Equal codes never warn; one step past the limit does.
      for (int i = 0; i < 7; i++) begin
         dir_sel = tbl[i][18];
         adc = '{valid: 1'b1, chan: pmn_chan_type'(tbl[i][17:16]), code: tbl[i][15:4]};
         @(posedge clk_in);
         #2;
         adc.valid = 1'b0;
         @(posedge clk_in);
         #2;
         e_warn = e_warn | tbl[i][3:0];
         chk("warn_out", {12'h000, e_warn}, {12'h000, warn});
         if (i == 1) begin
            host.clear_all();
            e_warn = 4'h0;
         end
      end
      adc = '{valid: 1'b1, chan: PMN_CHAN_VIN, code: 12'h0FF};
      @(posedge clk_in);
      #2;
      adc.valid = 1'b0;
      e_warn[PMN_WARN_VIN_UV] = 1'b1;
      rd(PMN_CODE_STATUS, st());
      host.clear_all();
      e_warn = 4'h0;
      // Live gate drive bit follows its pin both ways.
      set_pin(0, 1'b1);
      e_gate = 1'b1;
      rd(PMN_CODE_STATUS, st());
      set_pin(0, 1'b0);
      e_gate = 1'b0;
      rd(PMN_CODE_STATUS, st());
      // Latched faults survive their cause going away.
      set_pin(1, 1'b1);
      set_pin(1, 1'b0);
      e_oc = 1'b1;
      rd(PMN_CODE_STATUS, st());
      set_pin(2, 1'b1);
      set_pin(2, 1'b0);
      e_uv = 1'b1;
      rd(PMN_CODE_STATUS, st());
      comm_err = 1'b1;
      @(posedge clk_in);
      #2;
      comm_err = 1'b0;
      e_ce = 1'b1;
      other = 1'b1;
      rd(PMN_CODE_STATUS, st());
      other = 1'b0;
      // A send of another code must not clear; the real clear does.
      host.put(1'b0, 1'b0, 1'b1, 8'h05, 16'h0000);
      host.idle();
      rd(PMN_CODE_STATUS, st());
      host.clear_all();
      {e_oc, e_uv, e_ce} = 3'h0;
      rd(PMN_CODE_STATUS, st());
      // A pin still high after the clear latches again.
      set_pin(2, 1'b1);
      host.clear_all();
      repeat (2) @(posedge clk_in);
      e_uv = 1'b1;
      rd(PMN_CODE_STATUS, st());
      set_pin(2, 1'b0);
      // A second reset in mid-run restores the defaults.
      rst_in = 1'b1;
      @(posedge clk_in);
      #2;
      rst_in = 1'b0;
      e_uv = 1'b0;
      rd(PMN_CODE_CUR_HIGH, 16'h0FFF);
      rd(PMN_CODE_STATUS, st());
      repeat (3) @(posedge clk_in);
      chk("pending reads", 16'h0000, 16'(exp_q.size()));
      give_verdict();
   end

endmodule : power_monitor_limits_status_tb_top
